// ==== acp_config_port.sv ====
`timescale 1ns/10ps
`include "acp_regs.svh"

module acp_config_port (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Configuration pins.
  input wire logic interface_select_strap_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Mode outputs to the converter.
  output logic duty_cycle_stabilizer_en_o,
  output logic ddr_output_mode_o,
  output logic [1:0] power_state_code_o,
  output logic out_clock_invert_o,
  output logic [1:0] out_clock_phase_delay_o
);

  // ******************************************************************
  // Pin synchronisation and edge detection.
  // ******************************************************************
  acp_pkg::acp_pins_t pins_raw;
  acp_pkg::acp_pins_t pins_s;
  acp_pkg::acp_pins_t pins_d;

  assign pins_raw = '{strap: interface_select_strap_i, cs_n: cs_n_i,
                      sck: sck_i, sdi: sdi_i, sdo: sdo_i};

  acp_sync #(
    .W(5)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i(pins_raw),
    .sync_o(pins_s)
  );

  // Matches the synchroniser's reset, so no false frame start follows reset.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      pins_d <= '{strap: 1'b0, cs_n: 1'b0, sck: 1'b0, sdi: 1'b0,
                  sdo: 1'b0};
    else
      pins_d <= pins_s;
  end

  // Strap is sampled continuously so a board can move it live.
  wire serial_mode = !pins_s.strap;
  wire sck_rise = pins_s.sck && !pins_d.sck;
  wire sck_fall = !pins_s.sck && pins_d.sck;
  wire cs_fall = !pins_s.cs_n && pins_d.cs_n;
  wire cs_rise = pins_s.cs_n && !pins_d.cs_n;

  // ******************************************************************
  // Transfer sequencing.
  // ******************************************************************
  acp_pkg::acp_state_t state;
  acp_pkg::acp_state_t next_state;
  logic [4:0] bit_cnt;
  logic [14:0] shift_reg;

  wire in_shift = (state == acp_pkg::ST_SHIFT);
  wire take_bit = in_shift && sck_rise;
  wire last_bit = take_bit && (bit_cnt == `ACP_LAST_BIT);
  wire hdr_done = take_bit && (bit_cnt == `ACP_HDR_LAST);

  always_comb
  begin
    next_state = state;
    case (state)
      acp_pkg::ST_IDLE:
        if (serial_mode && cs_fall)
          next_state = acp_pkg::ST_SHIFT;
      acp_pkg::ST_SHIFT:
        if (!serial_mode || cs_rise)
          next_state = acp_pkg::ST_IDLE;
        else if (last_bit)
          next_state = acp_pkg::ST_DONE;
      acp_pkg::ST_DONE:
        if (!serial_mode || cs_rise)
          next_state = acp_pkg::ST_IDLE;
      default:
        next_state = acp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      state <= acp_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || state == acp_pkg::ST_IDLE)
    begin
      bit_cnt <= 5'h00;
      shift_reg <= 15'h0000;
    end
    else if (take_bit)
    begin
      bit_cnt <= bit_cnt + 5'h01;
      shift_reg <= {shift_reg[13:0], pins_s.sdi};
    end
  end

  // ******************************************************************
  // Word fields, read flag first, address and data MSB first.
  // ******************************************************************
  wire wr_read = shift_reg[14];
  wire [6:0] wr_addr = shift_reg[13:7];
  wire [7:0] wr_data = {shift_reg[6:0], pins_s.sdi};
  wire hdr_read = shift_reg[6];
  wire [6:0] hdr_addr = {shift_reg[5:0], pins_s.sdi};

  wire wr_fire = last_bit && !wr_read;
  wire wr_pwr = wr_fire && (wr_addr == `ACP_IDX_POWER_DOWN);
  wire wr_tim = wr_fire && (wr_addr == `ACP_IDX_CLK_TIMING);
  wire soft_rst = wr_fire && (wr_addr == `ACP_IDX_SOFT_RESET)
                  && wr_data[`ACP_RST_BIT];

  // ******************************************************************
  // Mode control registers.
  // ******************************************************************
  logic [1:0] pwr_code;
  logic tim_inv;
  logic [1:0] tim_phase;
  logic tim_dcs;
  logic [3:0] sleep_cnt;

  // The reset bit is never stored, so it is clear once the word ends.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || soft_rst)
      pwr_code <= `ACP_PWR_RESET;
    else if (wr_pwr)
      pwr_code <= wr_data[`ACP_PWR_MSB:`ACP_PWR_LSB];
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || soft_rst)
      {tim_inv, tim_phase, tim_dcs} <= `ACP_TIM_RESET;
    else if (wr_tim)
    begin
      tim_inv <= wr_data[`ACP_INV_BIT];
      tim_phase <= wr_data[`ACP_PHASE_MSB:`ACP_PHASE_LSB];
      tim_dcs <= wr_data[`ACP_DCS_BIT];
    end
  end

  // Brief forced sleep after a software reset.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      sleep_cnt <= 4'h0;
    else if (soft_rst)
      sleep_cnt <= 4'(`ACP_SLEEP_PULSE_CYC);
    else if (sleep_cnt != 4'h0)
      sleep_cnt <= sleep_cnt - 4'h1;
  end

  // ******************************************************************
  // Read-back path.
  // ******************************************************************
  // The write-only reset register reads as zero.
  wire [7:0] rd_mux =
    (hdr_addr == `ACP_IDX_POWER_DOWN) ? {6'h00, pwr_code} :
    (hdr_addr == `ACP_IDX_CLK_TIMING) ?
      {4'h0, tim_inv, tim_phase, tim_dcs} :
    `ACP_RD_UNMAPPED;

  logic reading;
  logic [7:0] rd_shift;
  wire rd_step = in_shift && sck_fall && reading
                 && (bit_cnt >= `ACP_DATA_FIRST);

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || state == acp_pkg::ST_IDLE)
    begin
      reading <= 1'b0;
      rd_shift <= 8'h00;
    end
    else if (hdr_done)
    begin
      reading <= hdr_read;
      rd_shift <= rd_mux;
    end
    else if (rd_step)
      rd_shift <= {rd_shift[6:0], 1'b0};
  end

  // Open drain: the output value is always low, only the enable moves.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || state == acp_pkg::ST_IDLE || cs_rise)
      sdo_oe_o <= 1'b0;
    else if (rd_step)
      sdo_oe_o <= !rd_shift[7];
  end

  always_ff @(posedge mclk_i)
  begin
    sdo_o <= 1'b0;
  end

  // ******************************************************************
  // Mode outputs, strap or register sourced.
  // ******************************************************************
  wire next_dcs = serial_mode ? tim_dcs : pins_s.cs_n;
  wire next_ddr = serial_mode ? 1'b0 : pins_s.sck;
  wire [1:0] next_pwr =
    !serial_mode ? {pins_s.sdi, pins_s.sdo} :
    (sleep_cnt != 4'h0) ? `ACP_PWR_SLEEP : pwr_code;
  wire next_inv = serial_mode && tim_inv;
  wire [1:0] next_phase = serial_mode ? tim_phase : 2'h0;

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      duty_cycle_stabilizer_en_o <= 1'b0;
      ddr_output_mode_o <= 1'b0;
      power_state_code_o <= `ACP_PWR_RESET;
      out_clock_invert_o <= 1'b0;
      out_clock_phase_delay_o <= 2'h0;
    end
    else
    begin
      duty_cycle_stabilizer_en_o <= next_dcs;
      ddr_output_mode_o <= next_ddr;
      power_state_code_o <= next_pwr;
      out_clock_invert_o <= next_inv;
      out_clock_phase_delay_o <= next_phase;
    end
  end

  // ******************************************************************
  // Checks.
  // ******************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_strap_dcs;
    !serial_mode |=> duty_cycle_stabilizer_en_o == $past(pins_s.cs_n);
  endproperty
  a_strap_dcs: assert property (p_strap_dcs)
    else $error("strap stabilizer level wrong");

  property p_strap_ddr;
    !serial_mode && pins_s.sck |=> ddr_output_mode_o;
  endproperty
  a_strap_ddr: assert property (p_strap_ddr)
    else $error("strap output mode wrong");

  property p_strap_pwr;
    !serial_mode |=>
      power_state_code_o == {$past(pins_s.sdi), $past(pins_s.sdo)};
  endproperty
  a_strap_pwr: assert property (p_strap_pwr)
    else $error("strap power code wrong");

  property p_extra_edges;
    state == acp_pkg::ST_DONE && sck_rise |=> $stable(bit_cnt)
      && bit_cnt == `ACP_WORD_BITS;
  endproperty
  a_extra_edges: assert property (p_extra_edges)
    else $error("extra clock edge was taken");

  property p_write_pwr;
    wr_pwr && !soft_rst |=> ##1
      power_state_code_o == $past(wr_data[1:0], 2) || sleep_cnt != 4'h0;
  endproperty
  a_write_pwr: assert property (p_write_pwr)
    else $error("power register write lost");

  property p_read_keeps;
    last_bit && wr_read |=> $stable(pwr_code) && $stable(tim_dcs)
      && $stable(tim_phase) && $stable(tim_inv);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read changed a register");

  property p_sdo_release;
    cs_rise |=> !sdo_oe_o;
  endproperty
  a_sdo_release: assert property (p_sdo_release)
    else $error("data-out still pulled after frame");

  property p_sdo_low;
    !sdo_o;
  endproperty
  a_sdo_low: assert property (p_sdo_low)
    else $error("data-out driven high");

  property p_soft_reset;
    soft_rst && serial_mode |=> pwr_code == 2'h0 && !tim_dcs
      && tim_phase == 2'h0 && !tim_inv ##1 power_state_code_o == 2'h3;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset did not clear and sleep");

  property p_reset_reads_zero;
    hdr_done && hdr_addr == `ACP_IDX_SOFT_RESET |=> rd_shift == 8'h00;
  endproperty
  a_reset_reads_zero: assert property (p_reset_reads_zero)
    else $error("reset register read not zero");

  property p_timing_write;
    wr_tim && !soft_rst |=> {tim_inv, tim_phase, tim_dcs}
      == $past(wr_data[3:0]);
  endproperty
  a_timing_write: assert property (p_timing_write)
    else $error("timing register write wrong");

  property p_read_bit;
    rd_step |=> sdo_oe_o == !$past(rd_shift[7]);
  endproperty
  a_read_bit: assert property (p_read_bit)
    else $error("read bit not presented");

  c_write: cover property (wr_tim);
  c_read: cover property (hdr_done && hdr_read);
  c_soft_reset: cover property (soft_rst);
  c_strap: cover property (!serial_mode ##1 ddr_output_mode_o);

endmodule

// ==== acp_regs.svh ====
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH

// ********************************************************************
// Register indices of the mode control bank.
// ********************************************************************
`define ACP_IDX_SOFT_RESET 7'h00
`define ACP_IDX_POWER_DOWN 7'h01
`define ACP_IDX_CLK_TIMING 7'h02

// ********************************************************************
// Field positions.
// ********************************************************************
`define ACP_RST_BIT 7
`define ACP_PWR_MSB 1
`define ACP_PWR_LSB 0
`define ACP_INV_BIT 3
`define ACP_PHASE_MSB 2
`define ACP_PHASE_LSB 1
`define ACP_DCS_BIT 0

// ********************************************************************
// Reset values, fixed read values and the forced sleep code.
// ********************************************************************
`define ACP_PWR_RESET 2'h0
`define ACP_TIM_RESET 4'h0
`define ACP_RD_UNMAPPED 8'h00
`define ACP_PWR_SLEEP 2'h3

// ********************************************************************
// Serial word framing.
// ********************************************************************
`define ACP_WORD_BITS 5'h10
`define ACP_LAST_BIT 5'h0f
`define ACP_HDR_LAST 5'h07
`define ACP_DATA_FIRST 5'h08

// ********************************************************************
// Timing.
// ********************************************************************
`define ACP_MCLK_PERIOD_NS 8
`define ACP_SLEEP_PULSE_NS 80
`define ACP_SLEEP_PULSE_CYC (`ACP_SLEEP_PULSE_NS / `ACP_MCLK_PERIOD_NS)

`endif

// ==== acp_pkg.sv ====
package acp_pkg;

  // ******************************************************************
  // Pin group and transfer states.
  // ******************************************************************
  typedef struct packed {
    logic strap;
    logic cs_n;
    logic sck;
    logic sdi;
    logic sdo;
  } acp_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } acp_state_t;

endpackage

// ==== acp_sync.sv ====
`timescale 1ns/10ps

module acp_sync #(
  parameter int W = 5
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] stage1;

  // ******************************************************************
  // Two flops per bit; only the second flop reads the first.
  // ******************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge mclk_i)
      begin
        if (!reset_n_i)
        begin
          stage1[i] <= 1'b0;
          sync_o[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= async_i[i];
          sync_o[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

// ==== acp_host_model.sv ====
`timescale 1ns/10ps

// ****
// Host side of the serial configuration port.
// ****
module acp_host_model (
  // Clock.
  input wire logic mclk_i,
  // Pins seen from the host.
  input wire logic sdo_oe_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  output logic sdo_pad_o
);
  logic strap_on;
  logic strap_sdo;

  initial
  begin
    strap_on = 1'b0;
    strap_sdo = 1'b0;
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end

  // The device only pulls low, so the pull-up gives the high level.
  assign sdo_pad_o = strap_on ? strap_sdo : !sdo_oe_i;

  // Half a link clock period of 80 ns.
  task automatic half();
    repeat (5) @(posedge mclk_i);
    #1;
  endtask

  // The clock stays low outside frames; rises past 16 carry toggling data.
  task automatic xfer(input logic [15:0] word, input int nbits,
                      output logic [7:0] rd);
    int i;
    rd = 8'h00;
    cs_n_o = 1'b0;
    half();
    for (i = 0; i < nbits; i++)
    begin
      sdi_o = (i < 16) ? word[15-i] : !sdi_o;
      half();
      sck_o = 1'b1;
      if (i >= 8 && i < 16)
        rd[15-i] = sdo_pad_o;
      half();
      sck_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    half();
  endtask

  task automatic set_pins(input logic cs, sck, sdi, sdo);
    strap_on = 1'b1;
    cs_n_o = cs;
    sck_o = sck;
    sdi_o = sdi;
    strap_sdo = sdo;
  endtask

  task automatic serial_mode();
    strap_on = 1'b0;
    cs_n_o = 1'b1;
    sck_o = 1'b0;
  endtask
endmodule

// ==== acp_config_port_test.sv ====
`timescale 1ns/10ps
`include "acp_regs.svh"

// ****
// Bench for the configuration port.
// ****
module acp_config_port_test;
  logic mclk_i;
  logic reset_n_i;
  logic strap;
  logic cs_n, sck, sdi, sdo_pad, sdo_o, sdo_oe_o, dcs_o, ddr_o, inv_o;
  logic [1:0] pwr_o;
  logic [1:0] phase_o;
  logic [1:0] pwr_m;
  logic [3:0] tim_m;
  logic [7:0] d;
  logic [6:0] a;
  int sleep_cycles = 0;
  int miscompares, checks_done, seed, n, k;

  initial mclk_i = 1'b0;
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
    if (pwr_o === 2'h3)
      sleep_cycles <= sleep_cycles + 1;

  acp_config_port dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .interface_select_strap_i(strap), .cs_n_i(cs_n), .sck_i(sck),
    .sdi_i(sdi), .sdo_i(sdo_pad), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .duty_cycle_stabilizer_en_o(dcs_o), .ddr_output_mode_o(ddr_o),
    .power_state_code_o(pwr_o), .out_clock_invert_o(inv_o),
    .out_clock_phase_delay_o(phase_o));

  acp_host_model host (
    .mclk_i(mclk_i), .sdo_oe_i(sdo_oe_o), .cs_n_o(cs_n), .sck_o(sck),
    .sdi_o(sdi), .sdo_pad_o(sdo_pad));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Unmapped places and the write-only reset register read as zero.
  function automatic logic [7:0] exp_read(input logic [6:0] addr);
    if (addr == 7'h01)
      return {6'h00, pwr_m};
    if (addr == 7'h02)
      return {4'h0, tim_m};
    return 8'h00;
  endfunction

  task automatic check_outs();
    repeat (4) @(posedge mclk_i);
    #1;
    check({6'h00, pwr_o}, {6'h00, pwr_m});
    check({7'h00, inv_o}, {7'h00, tim_m[3]});
    check({6'h00, phase_o}, {6'h00, tim_m[2:1]});
    check({7'h00, dcs_o}, {7'h00, tim_m[0]});
    check({5'h00, ddr_o, sdo_oe_o, sdo_o}, 8'h00);
  endtask

  // Short frames write nothing; the model follows only whole words.
  task automatic cmd(input logic r, input logic [6:0] addr,
                     input logic [7:0] dat, input int nb);
    logic [7:0] rd;
    host.xfer({r, addr, dat}, nb, rd);
    if (nb >= 16)
    begin
      if (r)
        check(rd, exp_read(addr));
      else if (addr == 7'h00 && dat[7])
      begin
        pwr_m = 2'h0;
        tim_m = 4'h0;
      end
      else if (addr == 7'h01)
        pwr_m = dat[1:0];
      else if (addr == 7'h02)
        tim_m = dat[3:0];
    end
    check_outs();
  endtask

  initial
  begin
    seed = 27067;
    miscompares = 0;
    checks_done = 0;
    reset_n_i = 1'b0;
    strap = 1'b0;
    pwr_m = 2'h0;
    tim_m = 4'h0;
    repeat (3) @(posedge mclk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    #1;
    check_outs();
    cmd(1'b0, 7'h00, 8'h80, 16);
    for (k = 0; k < 4; k++)
    begin
      cmd(1'b0, 7'h01, {6'h3f, k[1:0]}, 17 + k % 2);
      cmd(1'b1, 7'h01, 8'h00, 16);
    end
    for (k = 0; k < 8; k++)
    begin
      cmd(1'b0, 7'h02, {4'h5, k[2:0], 1'b1}, 16);
      cmd(1'b1, 7'h02, 8'hff, 18);
    end
    cmd(1'b0, 7'h01, 8'h00, 16);
    cmd(1'b0, 7'h00, 8'h7f, 16);
    n = sleep_cycles;
    cmd(1'b0, 7'h00, 8'hff, 16);
    check(8'(sleep_cycles - n), 8'(`ACP_SLEEP_PULSE_CYC));
    cmd(1'b0, 7'h01, 8'h02, 12);
    for (k = 0; k < 40; k++)
    begin
      n = $random(seed);
      d = 8'($random(seed));
      a = (n[1:0] == 2'h3) ? n[10:4] : {5'h00, n[1:0]};
      if (d[2:1] != 2'h0)
        d[0] = 1'b1;
      cmd(n[3], a, d, (n[13:12] == 2'h0) ? 12 : 16 + n[14]);
    end
    strap = 1'b1;
    for (k = 0; k < 16; k++)
    begin
      host.set_pins(k[3], k[2], k[1], k[0]);
      repeat (6) @(posedge mclk_i);
      #1;
      check({4'h0, dcs_o, ddr_o, pwr_o}, 8'(k));
      check({5'h00, inv_o, phase_o}, 8'h00);
    end
    host.serial_mode();
    strap = 1'b0;
    repeat (6) @(posedge mclk_i);
    #1;
    cmd(1'b0, 7'h00, 8'h80, 16);
    cmd(1'b0, 7'h02, 8'h0b, 16);
    give_verdict();
  end

  // Roughly four times the expected length of the run.
  initial
  begin
    #400000;
    miscompares++;
    give_verdict();
  end
endmodule
